// >>> gpm_defs.svh
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define GPM_ADDR_W 7
`define GPM_OFS_PD_MASK 7'h0D
`define GPM_OFS_SYNC_REF 7'h0E
`define GPM_RST_PD_MASK 8'h00
`define GPM_RST_SYNC_REF 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define GPM_BIT_KEEP_CLOCK_BUFFER_ON 3
`define GPM_BIT_KEEP_REFERENCE_AMP_ON 2
`define GPM_BIT_BANDGAP_OFF_IN_SLEEP 1
`define GPM_BIT_SYNC_PIN_FUNCTION 7
// ----------------------------------------
// serial frame: rw, address, data, msb first
// ----------------------------------------
`define GPM_FRAME_BITS 16
`define GPM_CMD_BITS 8
`define GPM_CNT_W 5
`define GPM_CLK_PERIOD_NS 10
`endif

// >>> gpm_pkg.sv
package gpm_pkg;
   typedef enum logic [1:0] {
      GPM_AWAKE  = 2'b00,
      GPM_ASLEEP = 2'b01,
      GPM_WAKING = 2'b10
   } gpm_pwr_state_t;
endpackage

// >>> gpm_global_powerdown_mask_regs.sv
`timescale 1ns/1ns
`include "gpm_defs.svh"
// Operation
// - mask bit 3 low lets the sampling clock buffer power down in global sleep, high keeps it running.
// - mask bit 2 low lets the reference amplifier power down in global sleep, high keeps it powered.
// - mask bit 1 is inverted: low keeps the bandgap on in global sleep, high switches it off.
// - with the bandgap switched off in sleep the wake-up time after leaving sleep is longer.
// - masks act only during global sleep and reset to zero, so by default buffer and amp sleep, bandgap stays on.
// - an asserted global sleep request powers blocks down as the mask register selects.
// - with the pin function select bit low, a high sync-or-sleep pin enters global sleep under the mask.
module gpm_global_powerdown_mask_regs
   import gpm_pkg::*;
#(
   parameter int WAKE_SHORT_NS = 1000,
   parameter int WAKE_LONG_NS = 100000
) (
   input wire logic i_ref_clk,                  // 100 MHz clock
   input wire logic i_srst,                     // synchronous reset, active high
   input wire logic i_spi_cs_n,                 // serial port select, active low
   input wire logic i_spi_sclk,                 // serial port clock
   input wire logic i_spi_sdi,                  // serial data in
   output logic o_spi_sdo,                      // serial data out
   output logic o_spi_sdo_oe,                   // serial data out enable
   input wire logic i_global_sleep_request,     // global sleep register bit
   input wire logic i_sync_or_sleep_pin,        // shared sync or sleep pin
   output logic o_global_sleep,                 // global sleep in force
   output logic o_clock_buffer_pd,              // sampling clock buffer off
   output logic o_reference_amp_pd,             // reference amplifier off
   output logic o_bandgap_pd,                   // bandgap off
   output logic o_wake_busy,                    // wake-up in progress or asleep
   output logic [7:0] o_sync_ref_select         // sync and reference select register
);
   localparam int WAKE_SHORT_CYC = (WAKE_SHORT_NS + `GPM_CLK_PERIOD_NS - 1) / `GPM_CLK_PERIOD_NS;
   localparam int WAKE_LONG_CYC = (WAKE_LONG_NS + `GPM_CLK_PERIOD_NS - 1) / `GPM_CLK_PERIOD_NS;
   localparam logic [16:0] WAKE_SHORT_LD = 17'(WAKE_SHORT_CYC - 1);
   localparam logic [16:0] WAKE_LONG_LD = 17'(WAKE_LONG_CYC - 1);

   // refuse wake-up spans that the 17-bit counter cannot hold
   if (WAKE_SHORT_CYC < 1 || WAKE_LONG_CYC < WAKE_SHORT_CYC || WAKE_LONG_CYC > 131072) begin
      $error("wake-up times out of range");
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic sclk_d3_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sync1_q <= 4'h1;
         sync2_q <= 4'h1;
         sclk_d3_q <= 1'b0;
      end else begin
         sync1_q <= {i_sync_or_sleep_pin, i_spi_sdi, i_spi_sclk, i_spi_cs_n};
         sync2_q <= sync1_q;
         sclk_d3_q <= sync2_q[1];
      end
   end
   logic cs_act;
   logic sclk_rise;
   logic sclk_fall;
   logic sdi_s;
   logic pin_s;
   assign cs_act = ~sync2_q[0];
   assign sclk_rise = cs_act & sync2_q[1] & ~sclk_d3_q;
   assign sclk_fall = cs_act & ~sync2_q[1] & sclk_d3_q;
   assign sdi_s = sync2_q[2];
   assign pin_s = sync2_q[3];

   // ----------------------------------------
   // serial frame decode
   // ----------------------------------------
   logic [`GPM_CNT_W-1:0] cnt_q;
   logic [`GPM_FRAME_BITS-2:0] shift_q;
   logic [7:0] rd_q;
   logic rd_en_q;
   logic wr_commit;
   logic [`GPM_ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic [`GPM_ADDR_W-1:0] rd_addr;
   logic [7:0] pd_mask_q;
   logic [7:0] sync_ref_q;
   logic [7:0] rd_val;

   assign wr_commit = sclk_rise && cnt_q == `GPM_CNT_W'(`GPM_FRAME_BITS - 1) && !shift_q[`GPM_FRAME_BITS-2];
   assign wr_addr = shift_q[`GPM_FRAME_BITS-3:7];
   assign wr_data = {shift_q[6:0], sdi_s};
   assign rd_addr = {shift_q[5:0], sdi_s};

   always_comb begin
      unique case (rd_addr)
         `GPM_OFS_PD_MASK: rd_val = pd_mask_q;
         `GPM_OFS_SYNC_REF: rd_val = sync_ref_q;
         default: rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !cs_act) begin
         cnt_q <= '0;
         shift_q <= '0;
      end else if (sclk_rise) begin
         cnt_q <= (cnt_q == `GPM_CNT_W'(`GPM_FRAME_BITS - 1)) ? '0 : cnt_q + `GPM_CNT_W'(1);
         shift_q <= {shift_q[`GPM_FRAME_BITS-3:0], sdi_s};
      end
   end

   // read data goes out on falling edges so the master samples it on rising
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !cs_act) begin
         rd_q <= 8'h00;
         rd_en_q <= 1'b0;
         o_spi_sdo <= 1'b0;
      end else if (sclk_rise && cnt_q == `GPM_CNT_W'(`GPM_CMD_BITS - 1)) begin
         rd_q <= rd_val;
         rd_en_q <= shift_q[6];
      end else if (sclk_rise && cnt_q == `GPM_CNT_W'(`GPM_FRAME_BITS - 1)) begin
         rd_en_q <= 1'b0;
      end else if (sclk_fall && rd_en_q) begin
         o_spi_sdo <= rd_q[7];
         rd_q <= {rd_q[6:0], 1'b0};
      end
   end
   assign o_spi_sdo_oe = rd_en_q;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pd_mask_q <= `GPM_RST_PD_MASK;
         sync_ref_q <= `GPM_RST_SYNC_REF;
      end else if (wr_commit && wr_addr == `GPM_OFS_PD_MASK) begin
         pd_mask_q <= wr_data;
      end else if (wr_commit && wr_addr == `GPM_OFS_SYNC_REF) begin
         sync_ref_q <= wr_data;
      end
   end
   assign o_sync_ref_select = sync_ref_q;

   // ----------------------------------------
   // power-down control
   // ----------------------------------------
   logic sleep_d;
   assign sleep_d = i_global_sleep_request | (pin_s & ~sync_ref_q[`GPM_BIT_SYNC_PIN_FUNCTION]);

   // reserved mask bits are not looked at
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_global_sleep <= 1'b0;
         o_clock_buffer_pd <= 1'b0;
         o_reference_amp_pd <= 1'b0;
         o_bandgap_pd <= 1'b0;
      end else begin
         o_global_sleep <= sleep_d;
         o_clock_buffer_pd <= sleep_d & ~pd_mask_q[`GPM_BIT_KEEP_CLOCK_BUFFER_ON];
         o_reference_amp_pd <= sleep_d & ~pd_mask_q[`GPM_BIT_KEEP_REFERENCE_AMP_ON];
         o_bandgap_pd <= sleep_d & pd_mask_q[`GPM_BIT_BANDGAP_OFF_IN_SLEEP];
      end
   end

   // ----------------------------------------
   // wake-up timer
   // ----------------------------------------
   gpm_pwr_state_t state_q;
   logic [16:0] wake_cnt_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_q <= GPM_AWAKE;
         wake_cnt_q <= '0;
      end else begin
         unique case (state_q)
            GPM_AWAKE: begin
               if (sleep_d) begin
                  state_q <= GPM_ASLEEP;
               end
            end
            GPM_ASLEEP: begin
               if (!sleep_d) begin
                  state_q <= GPM_WAKING;
                  wake_cnt_q <= o_bandgap_pd ? WAKE_LONG_LD : WAKE_SHORT_LD;
               end
            end
            GPM_WAKING: begin
               if (sleep_d) begin
                  state_q <= GPM_ASLEEP;
               end else if (wake_cnt_q == '0) begin
                  state_q <= GPM_AWAKE;
               end else begin
                  wake_cnt_q <= wake_cnt_q - 17'h00001;
               end
            end
            default: state_q <= GPM_AWAKE;
         endcase
      end
   end
   assign o_wake_busy = (state_q != GPM_AWAKE);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_clkbuf_sleeps: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      i_global_sleep_request && !pd_mask_q[`GPM_BIT_KEEP_CLOCK_BUFFER_ON] |=> o_clock_buffer_pd)
      else $error("clock buffer not powered down");
   a_clkbuf_kept_on: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      pd_mask_q[`GPM_BIT_KEEP_CLOCK_BUFFER_ON] |=> !o_clock_buffer_pd)
      else $error("masked clock buffer powered down");
   a_refamp_sleeps: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      i_global_sleep_request && !pd_mask_q[`GPM_BIT_KEEP_REFERENCE_AMP_ON] |=> o_reference_amp_pd)
      else $error("reference amp not powered down");
   a_refamp_kept_on: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      pd_mask_q[`GPM_BIT_KEEP_REFERENCE_AMP_ON] |=> !o_reference_amp_pd)
      else $error("masked reference amp powered down");
   a_bandgap_off: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      i_global_sleep_request && pd_mask_q[`GPM_BIT_BANDGAP_OFF_IN_SLEEP] |=> o_bandgap_pd)
      else $error("bandgap not switched off");
   a_bandgap_stays: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      !pd_mask_q[`GPM_BIT_BANDGAP_OFF_IN_SLEEP] |=> !o_bandgap_pd)
      else $error("bandgap switched off while kept on");
   a_awake_all_on: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      !sleep_d |=> !o_clock_buffer_pd && !o_reference_amp_pd && !o_bandgap_pd)
      else $error("block powered down outside sleep");
   a_request_sleeps: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      i_global_sleep_request |=> o_global_sleep && o_wake_busy)
      else $error("sleep request ignored");
   a_pin_sleeps: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      pin_s && !sync_ref_q[`GPM_BIT_SYNC_PIN_FUNCTION] |=> o_global_sleep)
      else $error("sleep pin ignored");
   a_long_wake: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      state_q == GPM_ASLEEP && !sleep_d && o_bandgap_pd |=> wake_cnt_q == WAKE_LONG_LD && o_wake_busy)
      else $error("long wake-up not loaded");
endmodule

// >>> test_global_powerdown_mask_regs.sv
`timescale 1ns/1ns
`include "gpm_defs.svh"
module test_global_powerdown_mask_regs;
   import gpm_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic cs_n = 1'b1;
   logic sclk = 1'b0;
   logic sdi = 1'b0;
   logic req = 1'b0;
   logic pin = 1'b0;
   localparam int SHORT_NS = 50;
   localparam int LONG_NS = 200;
   logic sdo, sdo_oe, gsleep, cbuf_pd, ramp_pd, bg_pd, wake_busy;
   logic [7:0] sref, rv;
   int err_total = 0;
   int samples_checked = 0;
   int wk [6];
   logic [7:0] masks [6] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h0E, 8'hF1};

   gpm_global_powerdown_mask_regs #(.WAKE_SHORT_NS(SHORT_NS), .WAKE_LONG_NS(LONG_NS)) dut_u (
      .i_ref_clk(ref_clk), .i_srst(srst), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_sdi(sdi),
      .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .i_global_sleep_request(req), .i_sync_or_sleep_pin(pin),
      .o_global_sleep(gsleep), .o_clock_buffer_pd(cbuf_pd), .o_reference_amp_pd(ramp_pd),
      .o_bandgap_pd(bg_pd), .o_wake_busy(wake_busy), .o_sync_ref_select(sref));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one frame: rw, 7 address bits, 8 data bits, msb first, sclk phases of 6 clocks
   task automatic xfer(input logic rw, input logic [6:0] adr, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] f;
      f = {rw, adr, wd};
      rd = 8'h00;
      @(posedge ref_clk) cs_n <= 1'b0;
      tick(6);
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk) begin
            sclk <= 1'b0;
            sdi <= f[15-i];
         end
         tick(5);
         #1;
         if (i >= 8) rd[15-i] = sdo;
         if (i == 8) check({7'h00, sdo_oe}, {7'h00, rw});
         @(posedge ref_clk) sclk <= 1'b1;
         tick(5);
      end
      @(posedge ref_clk) sclk <= 1'b0;
      tick(6);
      @(posedge ref_clk) cs_n <= 1'b1;
      tick(6);
   endtask
   task automatic wr(input logic [6:0] adr, input logic [7:0] d);
      logic [7:0] x;
      xfer(1'b0, adr, d, x);
   endtask
   task automatic wait_awake(output int n);
      n = 0;
      while (wake_busy !== 1'b0 && n < 5000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      #1;
      check({7'h00, wake_busy}, 8'h00);
   endtask
   // sleep with a given mask, then wake and count the wake-up span
   task automatic nap(input logic [7:0] m, output int n);
      wr(`GPM_OFS_PD_MASK, m);
      @(posedge ref_clk) req <= 1'b1;
      tick(3);
      #1;
      check({6'h00, gsleep, wake_busy}, 8'h03);
      check({5'h00, cbuf_pd, ramp_pd, bg_pd}, {5'h00, ~m[3], ~m[2], m[1]});
      @(posedge ref_clk) req <= 1'b0;
      tick(2);
      #1;
      check({4'h0, gsleep, cbuf_pd, ramp_pd, bg_pd}, 8'h00);
      wait_awake(n);
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      tick(10);
      srst <= 1'b0;
      tick(4);
      #1;
      check({2'h0, gsleep, cbuf_pd, ramp_pd, bg_pd, wake_busy, 1'b0}, 8'h00);
      check(sref, `GPM_RST_SYNC_REF);
      xfer(1'b1, `GPM_OFS_PD_MASK, 8'h00, rv);
      check(rv, `GPM_RST_PD_MASK);
      wr(`GPM_OFS_PD_MASK, 8'hFF);
      xfer(1'b1, `GPM_OFS_PD_MASK, 8'h00, rv);
      check(rv, 8'hFF);
      check({4'h0, gsleep, cbuf_pd, ramp_pd, bg_pd}, 8'h00);
      wr(7'h11, 8'hA5);
      xfer(1'b1, 7'h11, 8'h00, rv);
      check(rv, 8'h00);
      @(posedge ref_clk) srst <= 1'b1;
      tick(3);
      @(posedge ref_clk) srst <= 1'b0;
      tick(4);
      xfer(1'b1, `GPM_OFS_PD_MASK, 8'h00, rv);
      check(rv, 8'h00);
      foreach (masks[k]) nap(masks[k], wk[k]);
      check({7'h00, wk[3] > wk[0]}, 8'h01);
      check(8'(wk[0]), 8'(SHORT_NS / `GPM_CLK_PERIOD_NS - 1));
      check(8'(wk[3]), 8'(LONG_NS / `GPM_CLK_PERIOD_NS - 1));
      check({7'h00, wk[5] == wk[0]}, 8'h01);
      wr(`GPM_OFS_SYNC_REF, 8'h5A);
      xfer(1'b1, `GPM_OFS_SYNC_REF, 8'h00, rv);
      check(rv, 8'h5A);
      @(posedge ref_clk) pin <= 1'b1;
      tick(6);
      #1;
      check({5'h00, gsleep, cbuf_pd, ramp_pd}, 8'h07);
      @(posedge ref_clk) pin <= 1'b0;
      tick(6);
      wait_awake(wk[0]);
      wr(`GPM_OFS_SYNC_REF, 8'h80);
      check(sref, 8'h80);
      @(posedge ref_clk) pin <= 1'b1;
      tick(6);
      #1;
      check({6'h00, gsleep, cbuf_pd}, 8'h00);
      @(posedge ref_clk) pin <= 1'b0;
      tick(2);
      finish_test();
   end
   initial begin
      tick(60000);
      err_total++;
      finish_test();
   end
endmodule
